/* verilog/dcma_output_scaler.sv */
/*
  dcma output scaler: per-channel source select, limit clamp and linear
  rescale onto the chosen current range, with an apb register file.
  assumes the analog quantities come from logic on CLK, and the option
  straps come from pins outside the clock domain.
*/
//
// Function
// - each channel picks its driving value from one selectable internal analog quantity.
// - below lower limit output range minimum, above upper limit output range maximum.
// - between limits output is range minimum plus k times value minus lower.
// - k is range current width divided by upper minus lower limit.
// - inhibit the function when upper minus lower limit is below 0.1 pu.
// - each channel selects its own range: -1..1, 0..1 or 4..20 mA.
// - lower limit is a per-unit setting in comparator base units.
// - upper limit is a per-unit setting in comparator base units.
// - channels grouped in two-channel sub-modules, rows 1 to 8 top to bottom.
// - at power-up create settings for every channel the option code installs.
// - each channel is named by slot letter plus row number 1 to 8.
`timescale 1ns/100ps
module dcma_output_scaler #(
  parameter int             NUM_CH      = 8,
  parameter int             NUM_SRC     = 16,
  parameter logic [7:0]     SLOT_LETTER = 8'h46
) (
  // clock and reset
  input  wire logic                                     CLK,
  input  wire logic                                     NRST,
  // apb slave
  input  wire logic                                     PSEL,
  input  wire logic                                     PENABLE,
  input  wire logic                                     PWRITE,
  input  wire logic [11:0]                              PADDR,
  input  wire logic [31:0]                              PWDATA,
  output logic [31:0]                                   PRDATA,
  output logic                                          PREADY,
  output logic                                          PSLVERR,
  // installed hardware straps, one per two-channel sub-module
  input  wire logic [NUM_CH/2-1:0]                      OPTION_CODE,
  // internal analog quantities, milli-pu
  input  wire logic [NUM_SRC-1:0][dcma_pkg::LIM_W-1:0]  ANALOG_IN,
  // output current targets, microamps
  output logic [NUM_CH-1:0][dcma_pkg::CUR_W-1:0]        CUR_OUT,
  output logic [NUM_CH-1:0]                             INHIBIT
);

  localparam int CH_W  = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int SRC_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  typedef enum logic [2:0] {S_INIT = 3'b001, S_START = 3'b010, S_WAIT = 3'b100} scan_st_t;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  dcma_pkg::ch_cfg_t                        cfg_r   [NUM_CH];
  logic [dcma_pkg::LIM_W-1:0]               lower_r [NUM_CH];
  logic [dcma_pkg::LIM_W-1:0]               upper_r [NUM_CH];
  logic [NUM_CH/2-1:0]                      opt_s1_r;
  logic [NUM_CH/2-1:0]                      opt_s2_r;
  logic [NUM_CH-1:0]                        present_r;
  logic [1:0]                               init_cnt_r;
  logic                                     init_done_r;
  logic                                     init_pulse;
  scan_st_t                                 st_r;
  logic [CH_W-1:0]                          ch_r;
  logic                                     start_r;
  logic signed [dcma_pkg::LIM_W-1:0]        x_sel;
  logic [1:0]                               rng_sel;
  logic                                     core_done;
  logic signed [dcma_pkg::CUR_W-1:0]        core_cur;
  logic                                     core_inh;
  logic                                     acc;
  logic                                     wr_ok;
  logic                                     ch_page;
  logic [3:0]                               a_ch;
  logic [3:0]                               a_ofs;
  logic                                     a_valid;
  logic [31:0]                              rd_data;
  logic                                     rd_err;

  // ----------------------------------------
  // strap synchroniser and power-up capture
  // ----------------------------------------
  // option pins are asynchronous: two flops before anything reads them
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      opt_s1_r <= '0;
      opt_s2_r <= '0;
    end else begin
      opt_s1_r <= OPTION_CODE;
      opt_s2_r <= opt_s1_r;
    end
  end

  // wait until the second stage holds a sampled value, then latch once
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      init_cnt_r  <= 2'h0;
      init_done_r <= 1'b0;
      present_r   <= '0;
    end else if (!init_done_r) begin
      init_cnt_r <= init_cnt_r + 2'h1;
      if (init_cnt_r == dcma_pkg::INIT_WAIT) begin
        init_done_r <= 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
          present_r[i] <= opt_s2_r[i/2];
        end
      end
    end
  end

  assign init_pulse = !init_done_r && (init_cnt_r == dcma_pkg::INIT_WAIT);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign acc     = PSEL && PENABLE;
  assign ch_page = PADDR[11:8] == dcma_pkg::ADDR_CH_PAGE;
  assign a_ch    = PADDR[7:4];
  assign a_ofs   = PADDR[3:0];
  assign a_valid = ch_page && (32'(a_ch) < NUM_CH) && present_r[a_ch[CH_W-1:0]];
  assign wr_ok   = acc && PREADY && PWRITE && a_valid && a_ofs != dcma_pkg::OFS_STATUS;

  // read mux; unmapped, absent channel or misaligned address is an error
  always_comb begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (PADDR == dcma_pkg::ADDR_PRESENT) begin
      rd_data = 32'(present_r);
    end else if (a_valid) begin
      case (a_ofs)
        dcma_pkg::OFS_CFG: begin
          rd_data[dcma_pkg::CFG_SRC_LSB +: 8]   = cfg_r[a_ch[CH_W-1:0]].src;
          rd_data[dcma_pkg::CFG_RANGE_LSB +: 2] = cfg_r[a_ch[CH_W-1:0]].rng;
          rd_data[dcma_pkg::CFG_EN_BIT]         = cfg_r[a_ch[CH_W-1:0]].en;
        end
        dcma_pkg::OFS_LOWER: rd_data = lower_r[a_ch[CH_W-1:0]];
        dcma_pkg::OFS_UPPER: rd_data = upper_r[a_ch[CH_W-1:0]];
        dcma_pkg::OFS_STATUS: begin
          rd_data[dcma_pkg::CUR_W-1:0]          = CUR_OUT[a_ch[CH_W-1:0]];
          rd_data[dcma_pkg::STAT_INH_BIT]       = INHIBIT[a_ch[CH_W-1:0]];
          rd_data[dcma_pkg::STAT_ROW_LSB +: 4]  = a_ch + 4'h1;
          rd_data[dcma_pkg::STAT_SLOT_LSB +: 8] = SLOT_LETTER;
        end
        default: rd_err = 1'b1;
      endcase
    end else begin
      rd_err = 1'b1;
    end
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc && !PREADY;
      PSLVERR <= acc && !PREADY && (rd_err || (PWRITE && PADDR == dcma_pkg::ADDR_PRESENT));
      PRDATA  <= (acc && !PREADY && !PWRITE) ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------
  // channel settings
  // ----------------------------------------
  // power-up creates defaults only for installed channels
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_r[i]   <= dcma_pkg::CFG_RESET;
        lower_r[i] <= '0;
        upper_r[i] <= '0;
      end
    end else if (init_pulse) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (opt_s2_r[i/2]) begin
          cfg_r[i]   <= dcma_pkg::CFG_INIT;
          lower_r[i] <= dcma_pkg::DEF_LOWER_MPU;
          upper_r[i] <= dcma_pkg::DEF_UPPER_MPU;
        end
      end
    end else if (wr_ok) begin
      case (a_ofs)
        dcma_pkg::OFS_CFG: begin
          cfg_r[a_ch[CH_W-1:0]].src <= PWDATA[dcma_pkg::CFG_SRC_LSB +: 8];
          cfg_r[a_ch[CH_W-1:0]].rng <=
            dcma_pkg::range_t'(PWDATA[dcma_pkg::CFG_RANGE_LSB +: 2]);
          cfg_r[a_ch[CH_W-1:0]].en  <= PWDATA[dcma_pkg::CFG_EN_BIT];
        end
        dcma_pkg::OFS_LOWER: lower_r[a_ch[CH_W-1:0]] <= PWDATA;
        dcma_pkg::OFS_UPPER: upper_r[a_ch[CH_W-1:0]] <= PWDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  // out-of-range source index reads as zero rather than wrapping
  always_comb begin
    x_sel = '0;
    if (32'(cfg_r[ch_r].src) < NUM_SRC) begin
      x_sel = $signed(ANALOG_IN[cfg_r[ch_r].src[SRC_W-1:0]]);
    end
    rng_sel = cfg_r[ch_r].rng;
  end

  // ----------------------------------------
  // channel scan
  // ----------------------------------------
  // one shared core, channels served round robin; refresh period is
  // roughly 52 cycles per channel, traded for a single divider
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r    <= S_INIT;
      ch_r    <= '0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (st_r)
        S_INIT: if (init_done_r) st_r <= S_START;
        S_START: begin
          start_r <= 1'b1;
          st_r    <= S_WAIT;
        end
        S_WAIT: begin
          if (core_done) begin
            ch_r <= (32'(ch_r) == NUM_CH - 1) ? '0 : ch_r + CH_W'(1);
            st_r <= S_START;
          end
        end
        default: st_r <= S_INIT;
      endcase
    end
  end

  dcma_scale_core u_core (
    .clk   (CLK),
    .nrst  (NRST),
    .start (start_r),
    .x     (x_sel),
    .lower (lower_r[ch_r]),
    .upper (upper_r[ch_r]),
    .rng   (rng_sel),
    .done  (core_done),
    .cur   (core_cur),
    .inh   (core_inh)
  );

  // ----------------------------------------
  // output targets
  // ----------------------------------------
  // absent or disabled channels hold their range minimum
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CUR_OUT <= '0;
      INHIBIT <= '0;
    end else if (st_r == S_WAIT && core_done) begin
      if (present_r[ch_r] && cfg_r[ch_r].en) begin
        CUR_OUT[ch_r] <= core_cur;
        INHIBIT[ch_r] <= core_inh;
      end else begin
        CUR_OUT[ch_r] <= dcma_pkg::range_lo(cfg_r[ch_r].rng);
        INHIBIT[ch_r] <= 1'b0;
      end
    end
  end

endmodule : dcma_output_scaler

/* shared/dcma_pkg.sv */
/*
  constants, types and helpers shared by the dcma output scaler and its
  arithmetic core. assumes limits held in milli-per-unit (0.001 pu) and
  currents in microamps, both signed two's complement.
*/
package dcma_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int LIM_W = 32;                 // limit / driving value, milli-pu
  localparam int CUR_W = 16;                 // output current, microamps
  localparam int NUM_W = 48;                 // dividend of the scaling step

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] ADDR_PRESENT = 12'h000;
  localparam logic [3:0]  ADDR_CH_PAGE = 4'h1;   // paddr[11:8] of channel page
  localparam logic [3:0]  OFS_CFG      = 4'h0;
  localparam logic [3:0]  OFS_LOWER    = 4'h4;
  localparam logic [3:0]  OFS_UPPER    = 4'h8;
  localparam logic [3:0]  OFS_STATUS   = 4'hc;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_SRC_LSB   = 0;
  localparam int CFG_RANGE_LSB = 8;
  localparam int CFG_EN_BIT    = 16;
  localparam int STAT_INH_BIT  = 16;
  localparam int STAT_ROW_LSB  = 20;
  localparam int STAT_SLOT_LSB = 24;

  // ----------------------------------------
  // ranges, limits, reset values
  // ----------------------------------------
  typedef enum logic [1:0] {
    RANGE_PM1  = 2'h0,                       // -1 .. 1 mA
    RANGE_0_1  = 2'h1,                       // 0 .. 1 mA
    RANGE_4_20 = 2'h2                        // 4 .. 20 mA
  } range_t;

  localparam logic signed [CUR_W-1:0] I_M1_UA  = 16'hfc18;
  localparam logic signed [CUR_W-1:0] I_0_UA   = 16'h0000;
  localparam logic signed [CUR_W-1:0] I_1_UA   = 16'h03e8;
  localparam logic signed [CUR_W-1:0] I_4_UA   = 16'h0fa0;
  localparam logic signed [CUR_W-1:0] I_20_UA  = 16'h4e20;

  localparam logic [LIM_W:0]     SPAN_MIN_MPU  = 33'h000000064; // 0.1 pu
  localparam logic [LIM_W-1:0]   DEF_LOWER_MPU = 32'h00000000;
  localparam logic [LIM_W-1:0]   DEF_UPPER_MPU = 32'h000003e8;  // 1 pu
  localparam logic [1:0]         INIT_WAIT     = 2'h3;          // strap settle

  typedef struct packed {
    logic   en;
    range_t rng;
    logic [7:0] src;
  } ch_cfg_t;

  localparam ch_cfg_t CFG_RESET = '{en: 1'b0, rng: RANGE_PM1, src: 8'h00};
  localparam ch_cfg_t CFG_INIT  = '{en: 1'b1, rng: RANGE_4_20, src: 8'h00};

  // ----------------------------------------
  // range ends
  // ----------------------------------------
  function automatic logic signed [CUR_W-1:0] range_lo(input range_t r);
    case (r)
      RANGE_PM1:  range_lo = I_M1_UA;
      RANGE_4_20: range_lo = I_4_UA;
      default:    range_lo = I_0_UA;
    endcase
  endfunction : range_lo

  function automatic logic signed [CUR_W-1:0] range_hi(input range_t r);
    case (r)
      RANGE_PM1:  range_hi = I_1_UA;
      RANGE_0_1:  range_hi = I_1_UA;
      RANGE_4_20: range_hi = I_20_UA;
      default:    range_hi = I_0_UA;
    endcase
  endfunction : range_hi

endpackage : dcma_pkg

/* verilog/dcma_scale_core.sv */
/*
  one-channel arithmetic: clamp, span check and linear rescale by a
  bit-serial divider. assumes inputs stay stable from start to done.
*/
`timescale 1ns/100ps
module dcma_scale_core (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                nrst,
  // request
  input  wire logic                                start,
  input  wire logic signed [dcma_pkg::LIM_W-1:0]   x,
  input  wire logic signed [dcma_pkg::LIM_W-1:0]   lower,
  input  wire logic signed [dcma_pkg::LIM_W-1:0]   upper,
  input  wire logic [1:0]                          rng,
  // answer
  output logic                                     done,
  output logic signed [dcma_pkg::CUR_W-1:0]        cur,
  output logic                                     inh
);

  typedef enum logic [2:0] {C_IDLE = 3'b001, C_DIV = 3'b010, C_DONE = 3'b100} core_st_t;

  core_st_t                                st_r;
  logic [dcma_pkg::NUM_W-1:0]              quo_r;
  logic [dcma_pkg::LIM_W+1:0]              rem_r;
  logic [dcma_pkg::LIM_W:0]                den_r;
  logic [5:0]                              cnt_r;
  logic signed [dcma_pkg::CUR_W-1:0]       base_r;
  logic signed [dcma_pkg::LIM_W:0]         span;
  logic signed [dcma_pkg::LIM_W:0]         off;
  logic signed [dcma_pkg::CUR_W-1:0]       i_lo;
  logic signed [dcma_pkg::CUR_W-1:0]       i_hi;
  logic [dcma_pkg::CUR_W-1:0]              i_width;
  logic [dcma_pkg::LIM_W+1:0]              trial;
  logic                                    ge;

  // ----------------------------------------
  // operand preparation
  // ----------------------------------------
  assign span    = (dcma_pkg::LIM_W+1)'(upper) - (dcma_pkg::LIM_W+1)'(lower);
  assign off     = (dcma_pkg::LIM_W+1)'(x) - (dcma_pkg::LIM_W+1)'(lower);
  assign i_lo    = dcma_pkg::range_lo(dcma_pkg::range_t'(rng));
  assign i_hi    = dcma_pkg::range_hi(dcma_pkg::range_t'(rng));
  assign i_width = dcma_pkg::CUR_W'(i_hi - i_lo);
  assign trial   = {rem_r[dcma_pkg::LIM_W:0], quo_r[dcma_pkg::NUM_W-1]};
  assign ge      = trial >= {1'b0, den_r};

  // ----------------------------------------
  // sequencing and divider
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r   <= C_IDLE;
      quo_r  <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      cnt_r  <= 6'h00;
      base_r <= '0;
      done   <= 1'b0;
      cur    <= '0;
      inh    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (start) begin
            base_r <= i_lo;
            if (rng == 2'h3 || span < $signed(dcma_pkg::SPAN_MIN_MPU)) begin
              cur  <= i_lo;
              inh  <= 1'b1;
              done <= 1'b1;
            end else if (x < lower) begin
              cur  <= i_lo;
              inh  <= 1'b0;
              done <= 1'b1;
            end else if (x > upper) begin
              cur  <= i_hi;
              inh  <= 1'b0;
              done <= 1'b1;
            end else begin
              // product fits 48 bits: 14-bit width (at most 16000) times 33-bit offset
              quo_r <= dcma_pkg::NUM_W'(i_width) * dcma_pkg::NUM_W'(off);
              den_r <= span;
              rem_r <= '0;
              cnt_r <= 6'(dcma_pkg::NUM_W - 1);
              inh   <= 1'b0;
              st_r  <= C_DIV;
            end
          end
        end
        C_DIV: begin
          rem_r <= ge ? trial - {1'b0, den_r} : trial;
          quo_r <= {quo_r[dcma_pkg::NUM_W-2:0], ge};
          cnt_r <= cnt_r - 6'h01;
          if (cnt_r == 6'h00) st_r <= C_DONE;
        end
        C_DONE: begin
          cur  <= base_r + $signed(quo_r[dcma_pkg::CUR_W-1:0]);
          done <= 1'b1;
          st_r <= C_IDLE;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end

endmodule : dcma_scale_core

/* test/dcma_output_scaler_properties.sv */
/*
  port checker for the dcma output scaler.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module dcma_scaler_checker #(
  parameter int         NUM_CH      = 8,
  parameter int         NUM_SRC     = 16,
  parameter logic [7:0] SLOT_LETTER = 8'h46
) (
  // clock and reset
  input wire logic                                    CLK,
  input wire logic                                    NRST,
  // apb
  input wire logic                                    PSEL,
  input wire logic                                    PENABLE,
  input wire logic                                    PWRITE,
  input wire logic [11:0]                             PADDR,
  input wire logic [31:0]                             PRDATA,
  input wire logic                                    PREADY,
  input wire logic                                    PSLVERR,
  // outputs
  input wire logic [NUM_CH-1:0][dcma_pkg::CUR_W-1:0]  CUR_OUT,
  input wire logic [NUM_CH-1:0]                       INHIBIT
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  a_one_wait: assert property ($rose(PENABLE) |-> !PREADY ##1 PREADY) else $error("wait state count wrong");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data not cleared");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_present_ro: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h000 && !PREADY
    |=> PREADY && PSLVERR) else $error("write to present map accepted");
  a_status_id: assert property (PREADY && !PSLVERR && !PWRITE && PADDR[11:8] == 4'h1
    && PADDR[3:0] == 4'hc |-> PRDATA[23:20] == PADDR[7:4] + 4'h1 && PRDATA[31:24] == SLOT_LETTER)
    else $error("channel row or slot wrong");
  a_inh_floor: assert property (INHIBIT[0] |-> CUR_OUT[0] inside {16'hfc18, 16'h0000, 16'h0fa0})
    else $error("inhibited channel not at range floor");
  a_cur_range: assert property ($signed(CUR_OUT[0]) >= -1000 && $signed(CUR_OUT[0]) <= 20000)
    else $error("current outside hardware ranges");
endmodule : dcma_scaler_checker

bind dcma_output_scaler dcma_scaler_checker #(.NUM_CH(NUM_CH), .NUM_SRC(NUM_SRC), .SLOT_LETTER(SLOT_LETTER)) u_chk (
  .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CUR_OUT(CUR_OUT), .INHIBIT(INHIBIT));

/* test/dcma_load_model.sv */
/*
  model of the equipment carrying each loop current.
  assumes currents in microamps on the scaler clock.
*/
`timescale 1ns/100ps
module dcma_load_model #(
  parameter int NUM_CH = 8
) (
  // clock
  input  wire logic                                   clk,
  // loop currents
  input  wire logic [NUM_CH-1:0][dcma_pkg::CUR_W-1:0] cur_ua,
  // current the loop cannot carry
  output logic [NUM_CH-1:0]                           over_range
);
  // a loop only carries -1 .. 20 mA; anything else is a scaler fault
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      over_range[i] <= $signed(cur_ua[i]) < dcma_pkg::I_M1_UA || $signed(cur_ua[i]) > dcma_pkg::I_20_UA;
    end
  end
endmodule : dcma_load_model

/* test/tb_dcma_output_scaler.sv */
/*
  self-checking bench: apb register checks, corner and random scaling.
  assumes sub-modules 0..2 fitted, 3 absent.
*/
`timescale 1ns/100ps
module tb_dcma_output_scaler;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic             CLK, NRST, PSEL, PENABLE, PWRITE, err;
  logic [11:0]      PADDR;
  logic [31:0]      PWDATA, PRDATA, rd;
  logic             PREADY, PSLVERR;
  logic [3:0]       opt;
  logic [15:0][31:0] ain;
  logic [7:0][15:0] cur;
  logic [7:0]       inh, over;
  int               failures, cmp_count, cyc;
  logic [1:0]       cr[9] = '{0, 0, 2, 1, 2, 2, 3, 2, 1};
  logic             ce[9] = '{1, 1, 1, 1, 1, 1, 1, 0, 1};
  int               clo[9] = '{-1247, -1247, 0, 404, 0, 0, 0, 0, 0};
  int               cup[9] = '{1247, 1247, 1260, 635, 100, 99, 1000, 1000, 1000};
  int               cx[9] = '{-2000, 1247, 0, 500, 50, 50, 500, 500, 5000};

  dcma_output_scaler #(.NUM_CH(8), .NUM_SRC(16), .SLOT_LETTER(8'h46)) DUT (.CLK(CLK), .NRST(NRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .OPTION_CODE(opt), .ANALOG_IN(ain), .CUR_OUT(cur), .INHIBIT(inh));
  dcma_load_model #(.NUM_CH(8)) load (.clk(CLK), .cur_ua(cur), .over_range(over));

  // clock and hang guard
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task chk(logic [31:0] got, logic [31:0] exp, string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // holds the request until pready is seen at an edge
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (n == 16) failures++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask : apb

  function automatic logic einh(logic [1:0] r, logic en, longint lo, longint up);
    return en && (r == 2'h3 || up - lo < longint'(dcma_pkg::SPAN_MIN_MPU));
  endfunction : einh

  function automatic logic [15:0] ecur(logic [1:0] r, logic en, longint lo, longint up, longint x);
    longint mn, mx;
    mn = (r == 2'h0) ? longint'(dcma_pkg::I_M1_UA) : (r == 2'h2) ? longint'(dcma_pkg::I_4_UA) : 0;
    mx = (r == 2'h3) ? 0 : (r == 2'h2) ? longint'(dcma_pkg::I_20_UA) : longint'(dcma_pkg::I_1_UA);
    if (!en || einh(r, en, lo, up) || x < lo) return mn[15:0];
    if (x > up) return mx[15:0];
    return 16'(mn + (mx - mn) * (x - lo) / (up - lo));
  endfunction : ecur

  // program one channel, let a full sweep pass, then compare
  task run(int ch, int src, logic [1:0] r, logic en, int lo, int up, int x);
    logic [11:0] pg;
    logic [15:0] e;
    pg = 12'h100 + 12'(ch * 16);
    // a source index past the table drives no input; the design reads zero for it
    if (src < 16) ain[src] <= 32'(x);
    apb(1'b1, pg, {15'h0, en, 6'h0, r, 8'(src)});
    apb(1'b1, pg + 12'h4, 32'(lo));
    apb(1'b1, pg + 12'h8, 32'(up));
    repeat (848) @(posedge CLK);
    e = ecur(r, en, lo, up, x);
    chk(32'(cur[ch]), 32'(e), "current");
    chk(32'(inh[ch]), 32'(einh(r, en, lo, up)), "inhibit");
    apb(1'b0, pg + 12'hc, 32'h0);
    chk({err, rd[16:0]}, {1'b0, einh(r, en, lo, up), e}, "status");
    chk(32'(rd[31:20]), 32'({8'h46, 4'(ch + 1)}), "status id");
    chk(32'(over), 32'h0, "loop range");
  endtask : run

  task summarize;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int lo, sp;
    NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h0; PWDATA = 32'h0;
    opt = 4'h7; failures = 0; cmp_count = 0; cyc = 0;
    void'($urandom(7750));
    for (int i = 0; i < 16; i++) ain[i] = $urandom;
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    repeat (8) @(posedge CLK);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h3f, "present");
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h00010200, "cfg default");
    apb(1'b0, 12'h108, 32'h0); chk(rd, 32'h3e8, "upper default");
    apb(1'b0, 12'h16c, 32'h0); chk(32'(err), 32'h1, "absent channel");
    apb(1'b1, 12'h000, 32'h5); chk(32'(err), 32'h1, "read-only write");
    apb(1'b0, 12'h800, 32'h0); chk(32'(err), 32'h1, "unmapped");
    apb(1'b0, 12'h102, 32'h0); chk(32'(err), 32'h1, "misaligned");
    $display("test registers done");
    for (int i = 0; i < 9; i++) run(i % 6, i, cr[i], ce[i], clo[i], cup[i], cx[i]);
    // source index beyond the table: driving value must read as zero
    run(2, 32, 2'h2, 1'b1, -500, 500, 0);
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      lo = int'($urandom % 4001) - 2000;
      sp = int'($urandom % 3000);
      run(int'($urandom % 6), int'($urandom % 16), 2'($urandom % 3), 1'b1, lo, lo + sp,
          lo - 300 + int'($urandom % (sp + 600)));
    end
    $display("test random done");
    summarize();
  end
endmodule : tb_dcma_output_scaler
